// *** iakr_pkg.sv ***
// Package: constants, states and carriers for interrupt acknowledge and key return
package iakr_pkg;
    localparam int NUM_SRC = 10;
    localparam int KEY_PINS = 8;
    localparam int KR_SRC = 7;
    localparam int IDX_W = 4;

    localparam logic [7:0] OFF_REQ_LO = 8'h00;
    localparam logic [7:0] OFF_REQ_HI = 8'h01;
    localparam logic [7:0] OFF_MASK_LO = 8'h04;
    localparam logic [7:0] OFF_MASK_HI = 8'h05;
    localparam logic [7:0] OFF_KEY_SEL = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h0D;

    localparam logic [9:0] RST_REQ = 10'h000;
    localparam logic [9:0] RST_MASK = 10'h3FF;
    localparam logic [7:0] RST_KEY_SEL = 8'h00;
    localparam logic RST_IE = 1'b0;
    localparam logic [7:0] KEY_SEL_RSVD = 8'h0E;
    localparam logic [5:0] MASK_HI_FILL = 6'h3F;

    localparam int CTRL_IE_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NMI_BIT = 1;
    localparam int STAT_HOLD_BIT = 2;

    localparam logic [15:0] NMI_VEC = 16'h0004;
    localparam logic [15:0] VEC_BASE = 16'h0004;

    // Request-to-service window; the core's instruction timing sets the actual figure
    localparam int LAT_MIN_CLK = 9;
    localparam int LAT_MAX_CLK = 19;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PSW = 2'b01,
        ST_PC = 2'b10,
        ST_VEC = 2'b11
    } iakr_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } iakr_push_t;

    typedef struct packed {
        logic load;
        logic nmi;
        logic [15:0] addr;
    } iakr_vec_t;

    function automatic logic [7:0] key_enables(input logic [7:0] sel);
        return {sel[7:4], {4{sel[0]}}};
    endfunction

    function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
        return VEC_BASE + {11'h000, idx, 1'b0};
    endfunction
endpackage

// *** iakr_keyret.sv ***
// Key return falling-edge detector with pin synchronisers
`timescale 1ns/1ps
module iakr_keyret
    import iakr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and selection
    input wire logic [7:0] pin_in,
    input wire logic [7:0] sel,
    // Event
    output logic evt
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] en;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 8'hFF;
            s2_q <= 8'hFF;
            s3_q <= 8'hFF;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign en = key_enables(sel);
    // All selected pins high before, one now low; a held-low pin masks others
    assign evt = (&(s3_q | ~en)) & (|(~s2_q & en));

    property p_kr_low_blocks;
        @(posedge clk) disable iff (!rst_n)
        (|(~s3_q & en)) |-> !evt;
    endproperty
    a_kr_low_blocks: assert property (p_kr_low_blocks) else $error("event while pin low");

    property p_kr_cause;
        @(posedge clk) disable iff (!rst_n)
        evt |-> (|(s3_q & ~s2_q & en));
    endproperty
    a_kr_cause: assert property (p_kr_cause) else $error("event without selected edge");
endmodule

// *** iakr_arbiter.sv ***
// Fixed-priority pick among eligible maskable requests
`timescale 1ns/1ps
module iakr_arbiter
    import iakr_pkg::*;
(
    // Flags
    input wire logic [NUM_SRC-1:0] flags,
    input wire logic [NUM_SRC-1:0] masks,
    // Pick
    output logic any,
    output logic [IDX_W-1:0] idx
);
    logic [NUM_SRC-1:0] elig;

    assign elig = flags & ~masks;
    assign any = |elig;

    // Lowest index is level 0, the highest priority
    always_comb begin
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i]) begin
                idx = IDX_W'(i);
            end
        end
    end
endmodule

// *** iakr_top.sv ***
// Interrupt acknowledge sequencer with key return detection
// Operation
// - Low select bit enables pins 0-3 group
// - Select bits 4-7 enable matching pin
// - Selected pins pulled up in input mode
// - Any selected pin low blocks new events
// - Non-maskable ignores enable, beats maskable
// - Non-maskable: push status, PC, clear, vector
// - New non-maskable preempts non-maskable handler
// - Eligible when flag set, mask clear, enabled
// - Request to service 9 to 19 clocks; not enforced here, latency follows the core's instruction timing
// - Simultaneous requests taken highest priority first
// - Blocked requests stay pending until acceptable
// - Maskable: push status, PC, clear, own vector
// - Flag before last clock: accept at end
// - Flag at last clock: after next instruction
// - Flag register access holds off one instruction
// - Maskable nesting only when handler re-enabled interrupts
// - Flag cleared on accept, reset, or write
// - Priority levels run 0 high to 9
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module iakr_top
    import iakr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Request sources
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic nmi_req,
    // Key pins
    input wire logic [7:0] key_pin_in,
    input wire logic [7:0] key_pin_out_mode,
    output logic [7:0] key_pullup_en,
    // Core
    input wire logic instr_end,
    input wire logic enable_ints_instr,
    input wire logic disable_ints_instr,
    input wire logic return_from_handler,
    input wire logic restore_enable,
    input wire logic [7:0] core_psw,
    input wire logic [15:0] core_pc,
    output iakr_push_t push,
    output iakr_vec_t vec,
    output logic global_enable,
    output logic svc_busy
);
    iakr_state_t st_q;
    logic [NUM_SRC-1:0] flags_q;
    logic [NUM_SRC-1:0] flags_d;
    logic [NUM_SRC-1:0] mask_q;
    logic [NUM_SRC-1:0] sets;
    logic [7:0] key_sel_q;
    logic ie_q;
    logic nmi_pend_q;
    logic hold_q;
    logic nmi_q;
    logic [15:0] vaddr_q;
    logic [7:0] rdata_q;
    logic [7:0] pullup_q;
    iakr_push_t push_q;
    iakr_vec_t vec_q;
    logic busy_q;
    logic kr_evt;
    logic arb_any;
    logic [IDX_W-1:0] arb_idx;
    logic flag_hit;
    logic blocked;
    logic gate_open;
    logic nmi_take;
    logic mi_take;
    logic take;
    logic [7:0] rmux;

    iakr_keyret iakr_keyret_inst (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(key_pin_in),
        .sel(key_sel_q),
        .evt(kr_evt)
    );

    iakr_arbiter iakr_arbiter_inst (
        .flags(flags_q),
        .masks(mask_q),
        .any(arb_any),
        .idx(arb_idx)
    );

    // Any touch of a flag or mask register, by read or write
    assign flag_hit = (reg_wr | reg_rd) & ((reg_addr == OFF_REQ_LO) |
        (reg_addr == OFF_REQ_HI) | (reg_addr == OFF_MASK_LO) |
        (reg_addr == OFF_MASK_HI));

    // Accessing instruction and its own end are both held off
    assign blocked = hold_q | flag_hit;

    // Only flags already set before this last clock are seen here
    // Acceptance only at instruction ends; latency follows the core's timing
    assign gate_open = instr_end & ~blocked & (st_q == ST_IDLE);

    assign nmi_take = gate_open & nmi_pend_q;
    assign mi_take = gate_open & ~nmi_pend_q & ie_q & arb_any;
    assign take = nmi_take | mi_take;

    // Hold spans the accessing instruction up to its end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (instr_end) begin
            hold_q <= 1'b0;
        end else if (flag_hit) begin
            hold_q <= 1'b1;
        end
    end

    // Hardware events, key return routed into its own slot
    always_comb begin
        sets = src_req;
        sets[KR_SRC] = kr_evt;
    end

    // Write, then clear on acceptance, then set: a new event always wins
    always_comb begin
        flags_d = flags_q;
        if (reg_wr && reg_addr == OFF_REQ_LO) begin
            flags_d[7:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == OFF_REQ_HI) begin
            flags_d[9:8] = reg_wdata[1:0];
        end
        if (mi_take) begin
            flags_d[arb_idx] = 1'b0;
        end
        flags_d = flags_d | sets;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= RST_REQ;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_q <= RST_MASK;
        end else if (reg_wr && reg_addr == OFF_MASK_LO) begin
            mask_q[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == OFF_MASK_HI) begin
            mask_q[9:8] <= reg_wdata[1:0];
        end
    end

    // Reserved select bits are forced low regardless of what is written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_sel_q <= RST_KEY_SEL;
        end else if (reg_wr && reg_addr == OFF_KEY_SEL) begin
            key_sel_q <= reg_wdata & ~KEY_SEL_RSVD;
        end
    end

    // Pull-up only on selected pins that are inputs; detection is unaffected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pullup_q <= 8'h00;
        end else begin
            pullup_q <= key_enables(key_sel_q) & ~key_pin_out_mode;
        end
    end

    // Non-maskable pending: a new request beats the clear of acceptance
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_req) begin
            nmi_pend_q <= 1'b1;
        end else if (nmi_take) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // Acceptance clears the enable ahead of any instruction effect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ie_q <= RST_IE;
        end else if (take) begin
            ie_q <= 1'b0;
        end else if (enable_ints_instr) begin
            ie_q <= 1'b1;
        end else if (disable_ints_instr) begin
            ie_q <= 1'b0;
        end else if (return_from_handler) begin
            ie_q <= restore_enable;
        end else if (reg_wr && reg_addr == OFF_CTRL) begin
            ie_q <= reg_wdata[CTRL_IE_BIT];
        end
    end

    // Save status word, then program counter, then branch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
            nmi_q <= 1'b0;
            vaddr_q <= 16'h0000;
            push_q <= '0;
            vec_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    vec_q.load <= 1'b0;
                    if (take) begin
                        st_q <= ST_PSW;
                        busy_q <= 1'b1;
                        nmi_q <= nmi_take;
                        vaddr_q <= nmi_take ? NMI_VEC : vector_of(arb_idx);
                        push_q <= '{valid: 1'b1, data: {8'h00, core_psw}};
                    end
                end
                ST_PSW: begin
                    st_q <= ST_PC;
                    push_q <= '{valid: 1'b1, data: core_pc};
                end
                ST_PC: begin
                    st_q <= ST_VEC;
                    push_q.valid <= 1'b0;
                    vec_q <= '{load: 1'b1, nmi: nmi_q, addr: vaddr_q};
                end
                ST_VEC: begin
                    st_q <= ST_IDLE;
                    busy_q <= 1'b0;
                    vec_q.load <= 1'b0;
                end
                default: begin
                    st_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        case (reg_addr)
            OFF_REQ_LO: rmux = flags_q[7:0];
            OFF_REQ_HI: rmux = {6'h00, flags_q[9:8]};
            OFF_MASK_LO: rmux = mask_q[7:0];
            OFF_MASK_HI: rmux = {MASK_HI_FILL, mask_q[9:8]};
            OFF_KEY_SEL: rmux = key_sel_q;
            OFF_CTRL: rmux = {7'h00, ie_q};
            OFF_STAT: rmux = {5'h00, hold_q, nmi_pend_q, busy_q};
            default: rmux = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rmux : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign key_pullup_en = pullup_q;
    assign push = push_q;
    assign vec = vec_q;
    assign global_enable = ie_q;
    assign svc_busy = busy_q;

    property p_kr_flag;
        @(posedge clk) disable iff (!rst_n)
        kr_evt |=> flags_q[KR_SRC];
    endproperty
    a_kr_flag: assert property (p_kr_flag) else $error("key event lost");

    property p_nmi_first;
        @(posedge clk) disable iff (!rst_n)
        (gate_open && nmi_pend_q) |=> (st_q == ST_PSW) && nmi_q ##2 vec_q.load && vec_q.nmi;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not taken first");

    property p_seq;
        @(posedge clk) disable iff (!rst_n)
        take |=> push_q.valid && push_q.data == {8'h00, $past(core_psw)}
            ##1 push_q.valid && push_q.data == $past(core_pc)
            ##1 !push_q.valid && vec_q.load;
    endproperty
    a_seq: assert property (p_seq) else $error("save order wrong");

    property p_ie_clr;
        @(posedge clk) disable iff (!rst_n)
        take |=> !ie_q;
    endproperty
    a_ie_clr: assert property (p_ie_clr) else $error("enable not cleared");

    property p_masked_gate;
        @(posedge clk) disable iff (!rst_n)
        (vec_q.load && !vec_q.nmi) |-> $past(ie_q, 3) && !$past(mask_q[arb_idx], 3);
    endproperty
    a_masked_gate: assert property (p_masked_gate) else $error("ineligible vectored");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (instr_end && (hold_q || flag_hit) && st_q == ST_IDLE) |=> st_q == ST_IDLE;
    endproperty
    a_hold: assert property (p_hold) else $error("accepted during hold");

    property p_ack_clr;
        @(posedge clk) disable iff (!rst_n)
        (mi_take && !sets[arb_idx]) |=> !flags_q[$past(arb_idx)];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("flag kept after accept");

    property p_prio;
        @(posedge clk) disable iff (!rst_n)
        mi_take |-> ((flags_q & ~mask_q) & ((10'h001 << arb_idx) - 10'h001)) == 10'h000;
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority taken");

    property p_vec_addr;
        @(posedge clk) disable iff (!rst_n)
        mi_take |-> ##3 vec_q.addr == vector_of($past(arb_idx, 3));
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("wrong vector");
endmodule

// *** iakr_core_model.sv ***
// Core model: instruction pacing, saved status word and program counter
`timescale 1ns/1ps
module iakr_core_model
    import iakr_pkg::*;
#(
    parameter logic [7:0] STATUS_WORD = 8'hA5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pacing
    input wire logic [3:0] instr_len,
    // Acknowledge side
    input wire logic svc_busy,
    input wire iakr_vec_t vec,
    // Core state
    output logic instr_end,
    output logic [7:0] core_psw,
    output logic [15:0] core_pc
);
    logic [3:0] cnt_q;
    logic [15:0] pc_q;

    // Core stalls while the acknowledge sequence owns the bus
    assign instr_end = (cnt_q == instr_len) && !svc_busy;
    assign core_psw = STATUS_WORD;
    assign core_pc = pc_q;

    always_ff @(posedge clk) begin
        if (!rst_n || svc_busy || instr_end) begin
            cnt_q <= 4'h1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Vector load replaces the return point, so the pushed value is the old PC
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_q <= 16'h0100;
        end else if (vec.load) begin
            pc_q <= vec.addr;
        end else if (instr_end) begin
            pc_q <= pc_q + 16'h0001;
        end
    end
endmodule

// *** test_interrupt_acknowledge_keyreturn.sv ***
// Testbench for interrupt acknowledge and key return
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_interrupt_acknowledge_keyreturn;
    import iakr_pkg::*;
    localparam logic [7:0] CORE_PSW = 8'hA5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [NUM_SRC-1:0] src_req = 10'h000;
    logic nmi_req = 1'b0;
    logic [7:0] key_pin_in = 8'hFF;
    logic [7:0] key_pin_out_mode = 8'h00;
    logic [7:0] key_pullup_en;
    logic return_from_handler = 1'b0;
    logic restore_enable = 1'b0;
    logic ei = 1'b0;
    logic di = 1'b0;
    logic instr_end;
    logic [7:0] core_psw;
    logic [15:0] core_pc;
    iakr_push_t push;
    iakr_vec_t vec;
    logic global_enable;
    logic svc_busy;
    int failures = 0;
    int total_checks = 0;
    logic [15:0] pushes[$];

    always #20 clk = ~clk;
    always @(posedge clk) if (push.valid === 1'b1) pushes.push_back(push.data);

    iakr_top iakr_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_req(src_req), .nmi_req(nmi_req), .key_pin_in(key_pin_in),
        .key_pin_out_mode(key_pin_out_mode), .key_pullup_en(key_pullup_en),
        .instr_end(instr_end), .enable_ints_instr(ei), .disable_ints_instr(di),
        .return_from_handler(return_from_handler), .restore_enable(restore_enable),
        .core_psw(core_psw), .core_pc(core_pc), .push(push), .vec(vec),
        .global_enable(global_enable), .svc_busy(svc_busy));

    iakr_core_model #(.STATUS_WORD(CORE_PSW)) iakr_core_model_inst (.clk(clk), .rst_n(rst_n),
        .instr_len(4'h6), .svc_busy(svc_busy), .vec(vec), .instr_end(instr_end),
        .core_psw(core_psw), .core_pc(core_pc));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic pulse_src(input logic [9:0] s, input logic n);
        pushes.delete();
        @(posedge clk);
        src_req <= s;
        nmi_req <= n;
        @(posedge clk);
        src_req <= 10'h000;
        nmi_req <= 1'b0;
    endtask

    task automatic ret_handler();
        pushes.delete();
        @(posedge clk);
        return_from_handler <= 1'b1;
        restore_enable <= 1'b1;
        @(posedge clk);
        return_from_handler <= 1'b0;
    endtask

    task automatic pulse_ie(input logic e, input logic d);
        pushes.delete();
        @(posedge clk);
        ei <= e;
        di <= d;
        @(posedge clk);
        ei <= 1'b0;
        di <= 1'b0;
        @(negedge clk);
        `CHK("ie_instr", e, global_enable)
    endtask

    task automatic wait_vec(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (vec.load !== 1'b1 && c < 40);
    endtask

    task automatic expect_vec(input string n, input logic nmi, input logic [15:0] addr);
        int c;
        logic [15:0] pc;
        wait_vec(c);
        pc = core_pc;
        `CHK(n, {1'b1, nmi, addr}, vec)
        `CHK("push_count", 2, pushes.size())
        `CHK("psw_push", {8'h00, CORE_PSW}, pushes[0])
        `CHK("pc_push", pc, pushes[1])
        `CHK("ie_clear", 1'b0, global_enable)
    endtask

    task automatic key_try(input logic [7:0] pins, input logic [7:0] exp, input string n);
        logic [7:0] d;
        @(posedge clk);
        key_pin_in <= pins;
        repeat (6) @(posedge clk);
        rd(OFF_REQ_LO, d);
        `CHK(n, exp, d)
        wr(OFF_REQ_LO, 8'h00);
    endtask

    task automatic t_regs();
        logic [7:0] a [6];
        logic [7:0] e [6];
        logic [7:0] d;
        a = '{OFF_REQ_LO, OFF_REQ_HI, OFF_MASK_LO, OFF_MASK_HI, OFF_KEY_SEL, 8'h3F};
        e = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            `CHK("reset_read", e[i], d)
        end
    endtask

    task automatic t_key();
        logic [7:0] d;
        // Key mask is still set from reset, so changing the select is safe
        wr(OFF_KEY_SEL, 8'h11);
        wr(OFF_REQ_LO, 8'h00);
        rd(OFF_KEY_SEL, d);
        `CHK("key_sel", 8'h11, d)
        @(posedge clk);
        key_pin_out_mode <= 8'h10;
        repeat (3) @(negedge clk);
        `CHK("pullup", 8'h0F, key_pullup_en)
        key_try(8'hFB, 8'h80, "low_group");
        key_try(8'hEB, 8'h00, "held_low");
        key_try(8'hFF, 8'h00, "release");
        key_try(8'hDF, 8'h00, "unselected");
        key_try(8'hEF, 8'h80, "out_mode_pin");
        key_try(8'hFF, 8'h00, "idle");
    endtask

    task automatic t_mask();
        logic [7:0] d;
        int c;
        wr(OFF_CTRL, 8'h01);
        wr(OFF_MASK_LO, 8'hD7);
        pulse_src(10'h028, 1'b0);
        expect_vec("vec_first", 1'b0, 16'h000A);
        rd(OFF_REQ_LO, d);
        `CHK("req_left", 8'h20, d)
        wait_vec(c);
        `CHK("nest_held", 40, c)
        ret_handler();
        expect_vec("vec_second", 1'b0, 16'h000E);
    endtask

    task automatic t_nmi();
        pulse_src(10'h000, 1'b1);
        expect_vec("nmi_no_ie", 1'b1, NMI_VEC);
        ret_handler();
        wr(OFF_MASK_LO, 8'hF7);
        pulse_src(10'h008, 1'b1);
        expect_vec("nmi_first", 1'b1, NMI_VEC);
        pulse_src(10'h000, 1'b1);
        expect_vec("nmi_nested", 1'b1, NMI_VEC);
        ret_handler();
        expect_vec("mask_after", 1'b0, 16'h000A);
        ret_handler();
    endtask

    task automatic t_hold();
        int c;
        wr(OFF_MASK_LO, 8'hFF);
        pulse_src(10'h008, 1'b0);
        @(negedge clk);
        while (instr_end !== 1'b1) @(negedge clk);
        // Mask write lands in the first clock of the next instruction
        wr(OFF_MASK_LO, 8'hF7);
        wait_vec(c);
        `CHK("hold_cycles", 14, c)
        ret_handler();
    endtask

    task automatic t_nest();
        int c;
        wr(OFF_MASK_LO, 8'hD7);
        pulse_src(10'h008, 1'b0);
        expect_vec("nest_outer", 1'b0, 16'h000A);
        pulse_src(10'h020, 1'b0);
        wait_vec(c);
        `CHK("nest_wait", 40, c)
        pulse_ie(1'b1, 1'b0);
        expect_vec("nest_inner", 1'b0, 16'h000E);
        pulse_ie(1'b1, 1'b0);
        pulse_ie(1'b0, 1'b1);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_key();
        t_mask();
        t_nmi();
        t_hold();
        t_nest();
        end_sim();
    end

    // Whole run needs a few hundred clocks
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
